// *** verilog/debug_serial_command_sequencer.sv ***
// command decoder and sequencer for the background_debug_link serial port
// assumes the development system makes the link clock, the core answers reg and mem requests with one-cycle acks
// Overview of operation
// - core register, control register and resume commands need a halted core.
// - memory read, write, dump and fill steal bus cycles without halting.
// - nop, pc output and debug register commands run beside the core.
// - a command is one 16-bit op word plus optional extension words.
// - direction bit set reads to the host, clear writes into core or memory.
// - size field 00 byte, 01 word, 10 long, 11 reserved.
// - register class bit one picks address register, zero data register.
// - register field gives the register number inside the class.
// - addresses take two words, byte/word data one, long two, msw first.
// - each exchange is one 17-bit transfer; replies belong to earlier traffic.
// - op word transfer returns previous low result word or ok status.
// - transfer after an op word returns not-ready, ok after nop, pc output or go to a halted core, or illegal for unknown ops.
// - not-ready matters only during memory cycles; new transfer taken 32 clocks later.
// - memory read returns not-ready on low address word, then starts the read.
// - results come in the one (byte, word) or two (long) transfers after completion; last carries next op.
// - bus error on a debug access returns status one with data 0001.
// - status bit zero for normal completion, one for illegal, not-ready, error.
// - unused formats act as nop and return the illegal response.
// - core register read returns 32 bits, or bus error when not halted.
// - ok is 0/ffff, not-ready 1/0000, bus error 1/0001, illegal 1/ffff.
// - each transfer is shifted msb first in both directions.
`timescale 1ns/1ps
`default_nettype none

module debug_serial_command_sequencer (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic link_clk_in,
    input wire logic link_data_in,
    output logic link_data_out,
    input wire logic core_halted_in,
    output logic reg_req_out,
    output logic reg_we_out,
    output logic [1:0] reg_space_out,
    output logic [15:0] reg_sel_out,
    output logic [31:0] reg_wdata_out,
    input wire logic reg_ack_in,
    input wire logic reg_err_in,
    input wire logic [31:0] reg_rdata_in,
    output logic mem_req_out,
    output logic mem_we_out,
    output logic [1:0] mem_size_out,
    output logic [31:0] mem_addr_out,
    output logic [31:0] mem_wdata_out,
    input wire logic mem_ack_in,
    input wire logic mem_err_in,
    input wire logic [31:0] mem_rdata_in,
    output logic go_out,
    output logic pc_output_out,
    output logic busy_out
);
    import debug_seq_pkg::*;
    // ==========================================================
    // link domain: shifting on the host's clock
    logic link_rst_meta, link_rst, rx_tgl;
    logic [4:0] bit_cnt;
    logic [15:0] rx_shift, tx_shift, rx_word;
    logic [16:0] resp;
    // reset reaches the link side only while the host clocks it
    always_ff @(posedge link_clk_in) begin
        link_rst_meta <= rst_in;
        link_rst <= link_rst_meta;
    end
    // first bit comes straight from the held response, so it follows resp between frames
    assign link_data_out = (bit_cnt == 5'h00) ? resp[status_bit] : tx_shift[15];
    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            bit_cnt <= 5'h00;
            rx_shift <= 16'h0000;
            tx_shift <= 16'h0000;
            rx_word <= 16'h0000;
            rx_tgl <= 1'b0;
        end else begin
            rx_shift <= {rx_shift[14:0], link_data_in};
            // resp is quiet for many system clocks before a frame starts
            tx_shift <= (bit_cnt == 5'h00) ? resp[15:0] : {tx_shift[14:0], 1'b0};
            if (bit_cnt == last_bit_index) begin
                bit_cnt <= 5'h00;
                // control bit of the packet is dropped unread
                rx_word <= {rx_shift[14:0], link_data_in};
                rx_tgl <= ~rx_tgl;
            end else begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // ==========================================================
    // crossing of the received-word event
    logic rx_tgl_meta, rx_tgl_sync, rx_tgl_seen, rx_valid;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rx_tgl_meta <= 1'b0;
            rx_tgl_sync <= 1'b0;
            rx_tgl_seen <= 1'b0;
        end else begin
            rx_tgl_meta <= rx_tgl;
            rx_tgl_sync <= rx_tgl_meta;
            rx_tgl_seen <= rx_tgl_sync;
        end
    end
    // rx_word has been still since its toggle left the link side
    assign rx_valid = rx_tgl_sync ^ rx_tgl_seen;

    // ==========================================================
    // decode of a fresh op word
    logic [7:0] op;
    logic rw, legal, needs_halt, block_ok;
    logic [1:0] sz;
    logic [2:0] ext_need;
    cmd_kind_type kind;
    assign op = rx_word[op_msb:op_lsb];
    assign rw = rx_word[rw_bit];
    assign sz = rx_word[size_msb:size_lsb];
    always_comb begin
        legal = 1'b1;
        needs_halt = 1'b0;
        ext_need = 3'h0;
        kind = kind_nop;
        unique case (op)
            op_nop: legal = (rx_word[7:0] == 8'h00);
            op_pc_output: kind = kind_pc;
            op_go: begin
                kind = kind_go;
                needs_halt = 1'b1;
            end
            op_mem: begin
                kind = kind_mem;
                ext_need = rw ? 3'h2 : ((sz == size_long) ? 3'h4 : 3'h3);
            end
            op_block: begin
                kind = kind_block;
                ext_need = rw ? 3'h0 : ((sz == size_long) ? 3'h2 : 3'h1);
                legal = block_ok;
            end
            op_core_reg: begin
                kind = kind_core;
                needs_halt = 1'b1;
                ext_need = rw ? 3'h0 : 3'h2;
            end
            op_ctrl_reg: begin
                kind = kind_ctrl;
                needs_halt = 1'b1;
                ext_need = rw ? 3'h1 : 3'h3;
            end
            op_dbg_reg: begin
                kind = kind_dbg;
                ext_need = rw ? 3'h0 : 3'h2;
            end
            default: legal = 1'b0;
        endcase
        if ((kind == kind_mem || kind == kind_block) && sz == size_reserved) begin
            legal = 1'b0;
        end
    end

    // ==========================================================
    // sequencer
    typedef enum logic [1:0] {st_idle, st_ext, st_busy, st_result_lo} seq_state_type;
    seq_state_type state;
    cmd_kind_type cur_kind;
    logic cur_rw, halt_fault, launch, done, done_err;
    logic [1:0] cur_sz;
    logic [15:0] cur_word, lo_hold;
    logic [2:0] ext_left, ext_idx;
    logic [31:0] addr, wdata, blk_addr, aligned, next_blk_addr, rdata;
    // longs land on 0 mod 4, words on 0 mod 2; size 11 never gets this far
    assign aligned = ((cur_kind == kind_block) ? blk_addr : addr) &
                     ~{30'h0, cur_sz == size_long, cur_sz != size_byte};
    assign next_blk_addr = aligned + ((cur_sz == size_long) ? 32'h4 : ((cur_sz == size_word) ? 32'h2 : 32'h1));
    assign done = (mem_req_out & mem_ack_in) | (reg_req_out & reg_ack_in);
    assign done_err = (mem_req_out & mem_err_in) | (reg_req_out & reg_err_in);
    assign rdata = mem_req_out ? mem_rdata_in : reg_rdata_in;
    // the last extension word, or an op word with none, starts the work
    assign launch = rx_valid && ((state == st_ext && ext_left == 3'h1) ||
                                 (state == st_idle && legal && ext_need == 3'h0));
    assign busy_out = (state == st_busy);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state <= st_idle;
            resp <= resp_reset;
            cur_kind <= kind_nop;
            cur_rw <= 1'b0;
            cur_sz <= size_byte;
            cur_word <= 16'h0000;
            halt_fault <= 1'b0;
            ext_left <= 3'h0;
            ext_idx <= 3'h0;
            addr <= 32'h0;
            wdata <= 32'h0;
            lo_hold <= 16'h0000;
        end else begin
            unique case (state)
                st_idle: if (rx_valid) begin
                    // hold the op and its fields until the command ends
                    cur_kind <= kind;
                    cur_rw <= rw;
                    cur_sz <= (kind == kind_core || kind == kind_ctrl || kind == kind_dbg) ? size_long : sz;
                    cur_word <= rx_word;
                    halt_fault <= needs_halt & ~core_halted_in;
                    ext_left <= ext_need;
                    ext_idx <= 3'h0;
                    if (!legal) begin
                        resp <= {1'b1, resp_illegal_data};
                    end else if (ext_need != 3'h0) begin
                        resp <= {1'b1, resp_not_ready_data};
                        state <= st_ext;
                    end else if (needs_halt & ~core_halted_in) begin
                        resp <= {1'b1, resp_bus_err_data};
                    end else if (kind == kind_nop || kind == kind_pc || kind == kind_go) begin
                        resp <= {1'b0, resp_ok_data};
                    end else begin
                        resp <= {1'b1, resp_not_ready_data};
                        state <= st_busy;
                    end
                end
                st_ext: if (rx_valid) begin
                    // address first: two words for memory, msw first; one register number for control
                    if ((cur_kind == kind_mem && ext_idx < 3'h2) || (cur_kind == kind_ctrl && ext_idx == 3'h0)) begin
                        addr <= {addr[15:0], rx_word};
                    end else begin
                        wdata <= {wdata[15:0], rx_word};
                    end
                    ext_idx <= ext_idx + 3'h1;
                    ext_left <= ext_left - 3'h1;
                    resp <= {1'b1, resp_not_ready_data};
                    if (ext_left == 3'h1) begin
                        if (halt_fault) begin
                            resp <= {1'b1, resp_bus_err_data};
                            state <= st_idle;
                        end else begin
                            state <= st_busy;
                        end
                    end
                end
                st_busy: begin
                    // transfers arriving now are answered by the not-ready still held in resp
                    if (rx_valid) begin
                        resp <= {1'b1, resp_not_ready_data};
                    end
                    if (done_err) begin
                        resp <= {1'b1, resp_bus_err_data};
                        state <= st_idle;
                    end else if (done) begin
                        state <= st_idle;
                        if (!cur_rw) begin
                            resp <= {1'b0, resp_ok_data};
                        end else if (cur_sz == size_long) begin
                            resp <= {1'b0, rdata[31:16]};
                            lo_hold <= rdata[15:0];
                            state <= st_result_lo;
                        end else begin
                            // byte data sits in the low byte of the word
                            resp <= {1'b0, rdata[15:0]};
                        end
                    end
                end
                st_result_lo: if (rx_valid) begin
                    resp <= {1'b0, lo_hold};
                    state <= st_idle;
                end
            endcase
        end
    end

    // ==========================================================
    // block pointer and the read-or-write chain that makes dump and fill legal
    logic chain_read, chain_valid;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            blk_addr <= 32'h0;
            chain_valid <= 1'b0;
            chain_read <= 1'b0;
        end else begin
            if (state == st_busy && done && !done_err && (cur_kind == kind_mem || cur_kind == kind_block)) begin
                blk_addr <= next_blk_addr;
            end
            if (state == st_idle && rx_valid && legal) begin
                if (kind == kind_mem || kind == kind_block) begin
                    chain_valid <= 1'b1;
                    chain_read <= rw;
                end else if (kind != kind_nop) begin
                    // nop pads between block commands without breaking the chain
                    chain_valid <= 1'b0;
                end
            end
        end
    end
    assign block_ok = chain_valid && (chain_read == rw);

    // ==========================================================
    // requests to the core and to the bus
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            mem_req_out <= 1'b0;
            reg_req_out <= 1'b0;
        end else begin
            if (state == st_busy && (done || done_err)) begin
                mem_req_out <= 1'b0;
                reg_req_out <= 1'b0;
            end else if (state == st_busy && !mem_req_out && !reg_req_out) begin
                // stolen bus cycle; the core is not halted for it
                mem_req_out <= (cur_kind == kind_mem || cur_kind == kind_block);
                reg_req_out <= (cur_kind == kind_core || cur_kind == kind_ctrl || cur_kind == kind_dbg);
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            mem_we_out <= 1'b0;
            mem_size_out <= size_byte;
            mem_addr_out <= 32'h0;
            mem_wdata_out <= 32'h0;
            reg_we_out <= 1'b0;
            reg_space_out <= space_core;
            reg_sel_out <= 16'h0000;
            reg_wdata_out <= 32'h0;
        end else if (state == st_busy && !mem_req_out && !reg_req_out) begin
            mem_we_out <= ~cur_rw;
            mem_size_out <= cur_sz;
            mem_addr_out <= aligned;
            mem_wdata_out <= (cur_sz == size_long) ? wdata : {16'h0000, wdata[15:0]};
            reg_we_out <= ~cur_rw;
            unique case (cur_kind)
                kind_core: begin
                    reg_space_out <= space_core;
                    reg_sel_out <= {12'h000, cur_word[ad_bit], cur_word[reg_msb:0]};
                end
                kind_ctrl: begin
                    reg_space_out <= space_ctrl;
                    reg_sel_out <= addr[15:0];
                end
                default: begin
                    reg_space_out <= space_dbg;
                    reg_sel_out <= {12'h000, cur_word[dbg_reg_msb:0]};
                end
            endcase
            reg_wdata_out <= wdata;
        end
    end

    // ==========================================================
    // one-cycle actions that need no answer
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            go_out <= 1'b0;
            pc_output_out <= 1'b0;
        end else begin
            go_out <= launch && state == st_idle && kind == kind_go && core_halted_in;
            pc_output_out <= launch && state == st_idle && kind == kind_pc;
        end
    end

endmodule

`default_nettype wire

// *** verilog/debug_seq_pkg.sv ***
// constants, field layouts and command kinds of the debug serial command sequencer
// assumes a 17-bit msb-first serial link and a single system clock for all core-facing logic
package debug_seq_pkg;

    // ==========================================================
    // packet layout
    localparam int pkt_width = 17;
    localparam int data_width = 16;
    localparam int status_bit = 16;
    localparam logic [4:0] last_bit_index = 5'h10;

    // ==========================================================
    // response encodings
    localparam logic [15:0] resp_ok_data = 16'hffff;
    localparam logic [15:0] resp_not_ready_data = 16'h0000;
    localparam logic [15:0] resp_bus_err_data = 16'h0001;
    localparam logic [15:0] resp_illegal_data = 16'hffff;
    localparam logic [16:0] resp_reset = {1'b0, resp_ok_data};

    // ==========================================================
    // command word fields
    localparam int op_msb = 15;
    localparam int op_lsb = 8;
    localparam int rw_bit = 7;
    localparam int size_msb = 5;
    localparam int size_lsb = 4;
    localparam int ad_bit = 3;
    localparam int reg_msb = 2;
    localparam int dbg_reg_msb = 3;

    // ==========================================================
    // operand sizes
    localparam logic [1:0] size_byte = 2'h0;
    localparam logic [1:0] size_word = 2'h1;
    localparam logic [1:0] size_long = 2'h2;
    localparam logic [1:0] size_reserved = 2'h3;

    // ==========================================================
    // operation field codes
    localparam logic [7:0] op_nop = 8'h00;
    localparam logic [7:0] op_pc_output = 8'h08;
    localparam logic [7:0] op_go = 8'h0c;
    localparam logic [7:0] op_mem = 8'h19;
    localparam logic [7:0] op_block = 8'h1d;
    localparam logic [7:0] op_core_reg = 8'h21;
    localparam logic [7:0] op_ctrl_reg = 8'h28;
    localparam logic [7:0] op_dbg_reg = 8'h2d;

    // ==========================================================
    // register space selector on the register port
    localparam logic [1:0] space_core = 2'h0;
    localparam logic [1:0] space_ctrl = 2'h1;
    localparam logic [1:0] space_dbg = 2'h2;

    // gap after which the device takes a new transfer when no memory cycle runs
    localparam int accept_gap_cycles = 32;

    typedef enum logic [2:0] {
        kind_nop,
        kind_pc,
        kind_go,
        kind_mem,
        kind_block,
        kind_core,
        kind_ctrl,
        kind_dbg
    } cmd_kind_type;

endpackage

// *** test/debug_host_model.sv ***
// development system model: link clock master, 17-bit frames
// assumes the bench keeps the frame gap and calls xfer once per transfer
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
    output logic link_clk_out,
    output logic link_data_out,
    input wire logic link_rsp_in
);
    // ==========
    // frame shifter, clock still between frames
    initial begin
        link_clk_out = 1'b0;
        link_data_out = 1'b1;
    end
    // commands only come from the bench, never during core debug writes
    task automatic xfer(input logic [15:0] w, output logic [16:0] r);
        logic [16:0] p;
        p = {1'b0, w};
        for (int i = 16; i >= 0; i--) begin
            link_data_out = p[i];
            #80;
            r[i] = link_rsp_in;
            link_clk_out = 1'b1;
            #80;
            link_clk_out = 1'b0;
        end
        link_data_out = ~p[0]; // line driven with the inverse of the last bit between frames
    endtask
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #80 link_clk_out = 1'b1;
            #80 link_clk_out = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** test/debug_seq_monitor.sv ***
// assertions on the request, pulse and busy ports of the sequencer
// assumes binding to the top module; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module debug_seq_monitor (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic core_halted_in,
    input wire logic reg_req_out,
    input wire logic [1:0] reg_space_out,
    input wire logic reg_ack_in,
    input wire logic reg_err_in,
    input wire logic mem_req_out,
    input wire logic [1:0] mem_size_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic mem_ack_in,
    input wire logic mem_err_in,
    input wire logic go_out,
    input wire logic pc_output_out,
    input wire logic busy_out
);
    import debug_seq_pkg::*;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // ==========
    // access steps
    sequence s_mem_open;
        mem_req_out && !mem_ack_in && !mem_err_in;
    endsequence
    sequence s_mem_done;
        mem_req_out && (mem_ack_in || mem_err_in);
    endsequence
    a_halt_core_reg: assert property (reg_req_out && reg_space_out == space_core |-> core_halted_in)
        else $error("core register request while core runs");
    a_mem_held: assert property (s_mem_open |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_size_out))
        else $error("memory request changed before its answer");
    a_reg_held: assert property (reg_req_out && !reg_ack_in && !reg_err_in |=> reg_req_out && $stable(reg_space_out))
        else $error("register request changed before its answer");
    a_mem_release: assert property (s_mem_done |=> !mem_req_out)
        else $error("memory request kept after answer");
    a_mem_busy: assert property (mem_req_out |-> busy_out)
        else $error("memory access without busy");
    a_busy_ends: assert property (s_mem_done |-> ##[1:4] !busy_out)
        else $error("busy stuck after memory answer");
    a_size_legal: assert property (mem_req_out |-> mem_size_out != size_reserved)
        else $error("reserved size on memory port");
    a_go_halted: assert property (go_out |-> core_halted_in ##1 !go_out)
        else $error("resume pulse wrong");
    a_pc_pulse: assert property (pc_output_out |=> !pc_output_out)
        else $error("pc output pulse too long");
endmodule
bind debug_serial_command_sequencer debug_seq_monitor u_debug_seq_monitor (.clk_sys_in, .rst_in,
    .core_halted_in, .reg_req_out, .reg_space_out, .reg_ack_in, .reg_err_in, .mem_req_out, .mem_size_out,
    .mem_addr_out, .mem_ack_in, .mem_err_in, .go_out, .pc_output_out, .busy_out);
`default_nettype wire

// *** test/debug_serial_command_sequencer_tb_top.sv ***
// self-checking bench: host model on the link, bench answers reg and mem requests
// assumes the sequencer and its package compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; $display("mismatch %0t %h %h", $time, a, e); end end
module debug_serial_command_sequencer_tb_top;
    import debug_seq_pkg::*;
    localparam logic [16:0] ok = {1'b0, resp_ok_data};
    localparam logic [16:0] nr = {1'b1, resp_not_ready_data};
    localparam logic [16:0] be = {1'b1, resp_bus_err_data};
    localparam logic [16:0] il = {1'b1, resp_illegal_data};
    logic clk_sys_in, rst_in, lclk, ldi, ldo, halted, rq, rwe, mq, mwe, go, pc, busy, hit, fail;
    logic rack = 1'b0, rerr = 1'b0, mack = 1'b0, merr = 1'b0;
    logic [1:0] rsp, msz;
    logic [2:0] seen_k;
    logic [15:0] rsel;
    logic [31:0] rwd, madr, mwd, rdata, seen_a, seen_d;
    logic [16:0] r, r1, r2, r3;
    int error_cnt, n_compared, n_acc, n_go, n_pc, cnt, lat;
    debug_serial_command_sequencer u_debug_serial_command_sequencer (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .link_clk_in(lclk), .link_data_in(ldi), .link_data_out(ldo),
        .core_halted_in(halted), .reg_req_out(rq), .reg_we_out(rwe), .reg_space_out(rsp), .reg_sel_out(rsel),
        .reg_wdata_out(rwd), .reg_ack_in(rack), .reg_err_in(rerr), .reg_rdata_in(rdata), .mem_req_out(mq),
        .mem_we_out(mwe), .mem_size_out(msz), .mem_addr_out(madr), .mem_wdata_out(mwd), .mem_ack_in(mack),
        .mem_err_in(merr), .mem_rdata_in(rdata), .go_out(go), .pc_output_out(pc), .busy_out(busy));
    debug_host_model u_debug_host_model (.link_clk_out(lclk), .link_data_out(ldi), .link_rsp_in(ldo));
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    // ==========
    // access responder, latency set per test
    always @(posedge clk_sys_in) begin
        n_go <= n_go + int'(go);
        n_pc <= n_pc + int'(pc);
        if (mack | merr | rack | rerr) begin
            {mack, merr, rack, rerr} <= 4'h0;
            n_acc <= n_acc + 1;
        end else if (mq | rq) begin
            cnt <= cnt + 1;
            if (cnt >= lat) begin
                cnt <= 0;
                seen_a <= mq ? madr : {16'h0000, rsel};
                seen_d <= mq ? mwd : rwd;
                seen_k <= mq ? {mwe, msz} : {rwe, rsp};
                {mack, merr} <= {2{mq}} & {!fail, fail};
                {rack, rerr} <= {2{rq && !mq}} & {!fail, fail};
            end
        end
    end
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // gap of 40 clocks lets the reply settle before the next frame
    task automatic x(input logic [15:0] w, output logic [16:0] q);
        u_debug_host_model.xfer(w, q);
        #200;
    endtask
    // ==========
    // scenarios
    task automatic t_illegal();
        logic [15:0] bad [4];
        bad = '{16'hff00, 16'h19b0, 16'h1d80, 16'h0001};
        x(16'h0000, r);
        `CHK(r, ok)
        foreach (bad[i]) begin
            x(bad[i], r);
            `CHK(r, ok)
            x(16'h0000, r);
            `CHK(r, il)
        end
        `CHK(n_acc, 0)
        $display("test illegal done");
    endtask
    task automatic t_mem_read();
        @(posedge clk_sys_in) rdata <= 32'hdeadbeef;
        x(16'h19a0, r);
        x(16'h1234, r1);
        x(16'h5678, r2);
        `CHK({r1, r2}, {nr, nr})
        x(16'h0000, r1);
        x(16'h0000, r2);
        `CHK({r1, r2}, {1'b0, 16'hdead, 1'b0, 16'hbeef})
        `CHK({seen_k, seen_a}, {1'b0, size_long, 32'h12345678})
        x(16'h1d90, r);
        x(16'h0000, r);
        `CHK({r, seen_k, seen_a}, {1'b0, 16'hbeef, 1'b0, size_word, 32'h1234567c})
        $display("test mem read done");
    endtask
    task automatic t_mem_busy();
        lat = 1200;
        @(posedge clk_sys_in) rdata <= 32'h0000a5c3;
        x(16'h1990, r);
        `CHK(r, ok)
        x(16'h0000, r1);
        x(16'h0010, r2);
        x(16'h0000, r3);
        `CHK({r2, r3}, {nr, nr})
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk_sys_in);
        if (busy !== 1'b0) begin
            error_cnt++;
            report_and_stop();
        end
        x(16'h0000, r);
        `CHK(r, {1'b0, 16'ha5c3})
        `CHK({seen_k, seen_a}, {1'b0, size_word, 32'h00000010})
        lat = 2;
        fail = 1'b1;
        x(16'h1900, r);
        x(16'h0000, r);
        x(16'h0020, r);
        x(16'h00ab, r);
        x(16'h0000, r);
        `CHK(r, be)
        `CHK({seen_k, seen_d[7:0]}, {1'b1, size_byte, 8'hab})
        fail = 1'b0;
        $display("test mem busy done");
    endtask
    task automatic t_parallel();
        x(16'h2d03, r);
        x(16'haaaa, r);
        x(16'h5555, r);
        x(16'h0800, r);
        `CHK(r, ok)
        `CHK({seen_k, seen_a[3:0], seen_d}, {1'b1, space_dbg, 4'h3, 32'haaaa5555})
        x(16'h0c00, r);
        x(16'h0000, r);
        `CHK(r, be)
        `CHK({n_pc, n_go}, {32'sd1, 32'sd0})
        @(posedge clk_sys_in) halted <= 1'b1;
        x(16'h0c00, r);
        x(16'h0000, r);
        `CHK(r, ok)
        `CHK(n_go, 1)
        $display("test parallel done");
    endtask
    task automatic t_core_reg();
        x(16'h2800, r);
        x(16'h0801, r);
        x(16'h1111, r);
        x(16'h2222, r);
        x(16'h0000, r);
        `CHK({r, seen_k, seen_a[15:0], seen_d}, {ok, 1'b1, space_ctrl, 16'h0801, 32'h11112222})
        @(posedge clk_sys_in) rdata <= 32'hcafef00d;
        x(16'h218b, r);
        x(16'h0000, r1);
        x(16'h0000, r2);
        x(16'h0000, r3);
        hit = (r1 === {1'b0, 16'hcafe} && r2 === {1'b0, 16'hf00d})
            || (r2 === {1'b0, 16'hcafe} && r3 === {1'b0, 16'hf00d});
        `CHK(hit, 1'b1)
        `CHK({seen_k, seen_a[3:0]}, {1'b0, space_core, 4'hb})
        @(posedge clk_sys_in) halted <= 1'b0;
        x(16'h2188, r);
        x(16'h0000, r1);
        x(16'h0000, r2);
        hit = r1 === be || r2 === be;
        `CHK(hit, 1'b1)
        $display("test core reg done");
    endtask
    initial begin
        #400us;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        rst_in = 1'b1;
        halted = 1'b0;
        rdata = 32'h0;
        fail = 1'b0;
        lat = 2;
        // longer than ten clocks: the link side needs link edges inside reset
        u_debug_host_model.idle_clocks(4);
        @(posedge clk_sys_in) rst_in <= 1'b0;
        u_debug_host_model.idle_clocks(2);
        t_illegal();
        t_mem_read();
        t_mem_busy();
        t_parallel();
        t_core_reg();
        report_and_stop();
    end
endmodule
`default_nettype wire
